// file: common/gbc_regs.svh
`ifndef GBC_REGS_SVH
`define GBC_REGS_SVH

// register offsets
`define GBC_OFS_DIR      8'h17
`define GBC_OFS_DATA     8'h18
`define GBC_OFS_BUF1     8'h19
`define GBC_OFS_BUF2     8'h1A
`define GBC_OFS_C0_OFS_H 8'h1C
`define GBC_OFS_C0_OFS_M 8'h1D
`define GBC_OFS_C0_OFS_L 8'h1E
`define GBC_OFS_C0_GAN_H 8'h1F
`define GBC_OFS_C0_GAN_M 8'h20
`define GBC_OFS_C0_GAN_L 8'h21
`define GBC_OFS_C1_OFS_H 8'h22
`define GBC_OFS_C1_OFS_M 8'h23
`define GBC_OFS_C1_OFS_L 8'h24
`define GBC_OFS_C1_GAN_H 8'h25

// reset values
`define GBC_RST_ZERO 8'h00
`define GBC_RST_BUF1 8'h38
`define GBC_RST_BUF2 8'hC0

// write masks: the sampled pin field never stores
`define GBC_WMASK_ALL  8'hFF
`define GBC_WMASK_DATA 8'hC7

// field positions
`define GBC_PIN_COUNT    3
`define GBC_PIN_OUT_LSB  0
`define GBC_PIN_IN_LSB   3
`define GBC_BIT_POS_BUF  4
`define GBC_BIT_NEG_BUF  3
`define GBC_BIT_POS_PRE  7
`define GBC_BIT_NEG_PRE  6
`define GBC_BIT_AREG1_OD 2
`define GBC_BIT_AREG2_OD 1
`define GBC_BIT_DREG_OD  0

// cycles from a pin edge to the read field
`define GBC_SYNC_STAGES  2

`endif

// file: common/gbc_pkg.sv
package gbc_pkg;
   typedef logic [7:0] gbc_byte_t;
   typedef logic [23:0] gbc_word_t;
   typedef enum logic [3:0] {
      IDX_DIR = 4'h0,
      IDX_DATA = 4'h1,
      IDX_BUF1 = 4'h2,
      IDX_BUF2 = 4'h3,
      IDX_C0_OFS_H = 4'h4,
      IDX_C0_OFS_M = 4'h5,
      IDX_C0_OFS_L = 4'h6,
      IDX_C0_GAN_H = 4'h7,
      IDX_C0_GAN_M = 4'h8,
      IDX_C0_GAN_L = 4'h9,
      IDX_C1_OFS_H = 4'hA,
      IDX_C1_OFS_M = 4'hB,
      IDX_C1_OFS_L = 4'hC,
      IDX_C1_GAN_H = 4'hD
   } gbc_reg_idx_t;
endpackage

// file: design/gbc_byte_reg.sv
`timescale 1ns/100ps
`default_nettype none
module gbc_byte_reg #(
   parameter gbc_pkg::gbc_byte_t RST_VAL = 8'h00,
   parameter gbc_pkg::gbc_byte_t WR_MASK = 8'hFF
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic wr_en,
   input wire gbc_pkg::gbc_byte_t wr_data,
   output gbc_pkg::gbc_byte_t q
);
   gbc_pkg::gbc_byte_t byte_q;

   initial begin
      if ((RST_VAL & ~WR_MASK) != 8'h00) begin
         $error("reset value sets bits that can never be written");
      end
   end

   // masked-off bits keep their reset value forever
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         byte_q <= RST_VAL;
      end else if (wr_en) begin
         byte_q <= (byte_q & ~WR_MASK) | (wr_data & WR_MASK);
      end
   end

   assign q = byte_q;
endmodule
`default_nettype wire

// file: design/gbc_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module gbc_pin_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   initial begin
      if (WIDTH < 1) begin
         $error("pin synchroniser needs at least one bit");
      end
   end

   // first stage feeds only the second stage
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
      end
   end

   assign pin_sync = sync_q;
endmodule
`default_nettype wire

// file: design/gbc_regs_top.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "gbc_regs.svh"
module gbc_regs_top #(
   parameter int ADDR_W = 8,
   parameter int PINS = `GBC_PIN_COUNT
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] addr,
   input wire gbc_pkg::gbc_byte_t wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output gbc_pkg::gbc_byte_t rd_data,
   input wire logic [PINS-1:0] gpio_in,
   output logic [PINS-1:0] gpio_out,
   output logic [PINS-1:0] gpio_oe,
   output logic pos_ref_buffer_on,
   output logic neg_ref_buffer_on,
   output logic pos_ref_precharge_on,
   output logic neg_ref_precharge_on,
   output logic analog_reg1_overdrive,
   output logic analog_reg2_overdrive,
   output logic digital_reg_overdrive,
   output gbc_pkg::gbc_word_t chan0_offset_word,
   output gbc_pkg::gbc_word_t chan0_gain_word,
   output gbc_pkg::gbc_word_t chan1_offset_word,
   output gbc_pkg::gbc_byte_t chan1_gain_word_top
);
   localparam int NREG = 14;

   localparam logic [ADDR_W-1:0] OFS [NREG] = '{
      ADDR_W'(`GBC_OFS_DIR), ADDR_W'(`GBC_OFS_DATA),
      ADDR_W'(`GBC_OFS_BUF1), ADDR_W'(`GBC_OFS_BUF2),
      ADDR_W'(`GBC_OFS_C0_OFS_H), ADDR_W'(`GBC_OFS_C0_OFS_M),
      ADDR_W'(`GBC_OFS_C0_OFS_L), ADDR_W'(`GBC_OFS_C0_GAN_H),
      ADDR_W'(`GBC_OFS_C0_GAN_M), ADDR_W'(`GBC_OFS_C0_GAN_L),
      ADDR_W'(`GBC_OFS_C1_OFS_H), ADDR_W'(`GBC_OFS_C1_OFS_M),
      ADDR_W'(`GBC_OFS_C1_OFS_L), ADDR_W'(`GBC_OFS_C1_GAN_H)
   };

   localparam gbc_pkg::gbc_byte_t RST [NREG] = '{
      `GBC_RST_ZERO, `GBC_RST_ZERO, `GBC_RST_BUF1, `GBC_RST_BUF2,
      `GBC_RST_ZERO, `GBC_RST_ZERO, `GBC_RST_ZERO, `GBC_RST_ZERO,
      `GBC_RST_ZERO, `GBC_RST_ZERO, `GBC_RST_ZERO, `GBC_RST_ZERO,
      `GBC_RST_ZERO, `GBC_RST_ZERO
   };

   localparam gbc_pkg::gbc_byte_t WMASK [NREG] = '{
      `GBC_WMASK_ALL, `GBC_WMASK_DATA, `GBC_WMASK_ALL, `GBC_WMASK_ALL,
      `GBC_WMASK_ALL, `GBC_WMASK_ALL, `GBC_WMASK_ALL, `GBC_WMASK_ALL,
      `GBC_WMASK_ALL, `GBC_WMASK_ALL, `GBC_WMASK_ALL, `GBC_WMASK_ALL,
      `GBC_WMASK_ALL, `GBC_WMASK_ALL
   };

   initial begin
      if (ADDR_W < 6) begin
         $error("address too narrow for offset 0x025");
      end
      if (PINS != `GBC_PIN_COUNT) begin
         $error("pin fields are fixed at three bits");
      end
   end

   gbc_pkg::gbc_byte_t reg_q [NREG];
   logic [NREG-1:0] hit_wr;
   logic [PINS-1:0] pin_sync;
   gbc_pkg::gbc_byte_t rd_mux;
   gbc_pkg::gbc_byte_t rd_data_q;

   // one byte register per offset; unmapped writes hit nothing
   for (genvar i = 0; i < NREG; i++) begin : g_reg
      assign hit_wr[i] = wr_en && (addr == OFS[i]);
      gbc_byte_reg #(
         .RST_VAL(RST[i]),
         .WR_MASK(WMASK[i])
      ) u_reg (
         .clk_sys(clk_sys),
         .reset(reset),
         .wr_en(hit_wr[i]),
         .wr_data(wr_data),
         .q(reg_q[i])
      );
   end

   // pins are asynchronous to clk_sys
   gbc_pin_sync #(
      .WIDTH(PINS)
   ) u_pin_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin_in(gpio_in),
      .pin_sync(pin_sync)
   );

   always_comb begin
      rd_mux = 8'h00;
      for (int i = 0; i < NREG; i++) begin
         if (addr == OFS[i]) begin
            rd_mux = reg_q[i];
         end
      end
      // sampled levels replace the never-stored bits
      if (addr == OFS[gbc_pkg::IDX_DATA]) begin
         rd_mux[`GBC_PIN_IN_LSB +: PINS] = pin_sync;
      end
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_data_q <= 8'h00;
      end else if (rd_en) begin
         rd_data_q <= rd_mux;
      end else begin
         rd_data_q <= 8'h00;
      end
   end

   assign rd_data = rd_data_q;

   assign gpio_out = reg_q[gbc_pkg::IDX_DATA][`GBC_PIN_OUT_LSB +: PINS];
   assign gpio_oe = reg_q[gbc_pkg::IDX_DIR][PINS-1:0];

   assign pos_ref_buffer_on = reg_q[gbc_pkg::IDX_BUF1][`GBC_BIT_POS_BUF];
   assign neg_ref_buffer_on = reg_q[gbc_pkg::IDX_BUF1][`GBC_BIT_NEG_BUF];
   assign pos_ref_precharge_on = reg_q[gbc_pkg::IDX_BUF2][`GBC_BIT_POS_PRE];
   assign neg_ref_precharge_on = reg_q[gbc_pkg::IDX_BUF2][`GBC_BIT_NEG_PRE];
   assign analog_reg1_overdrive = reg_q[gbc_pkg::IDX_BUF2][`GBC_BIT_AREG1_OD];
   assign analog_reg2_overdrive = reg_q[gbc_pkg::IDX_BUF2][`GBC_BIT_AREG2_OD];
   assign digital_reg_overdrive = reg_q[gbc_pkg::IDX_BUF2][`GBC_BIT_DREG_OD];

   // calibration words are read whole by the filter; bytes land one write at a time
   assign chan0_offset_word = {reg_q[gbc_pkg::IDX_C0_OFS_H],
                               reg_q[gbc_pkg::IDX_C0_OFS_M],
                               reg_q[gbc_pkg::IDX_C0_OFS_L]};
   assign chan0_gain_word = {reg_q[gbc_pkg::IDX_C0_GAN_H],
                             reg_q[gbc_pkg::IDX_C0_GAN_M],
                             reg_q[gbc_pkg::IDX_C0_GAN_L]};
   assign chan1_offset_word = {reg_q[gbc_pkg::IDX_C1_OFS_H],
                               reg_q[gbc_pkg::IDX_C1_OFS_M],
                               reg_q[gbc_pkg::IDX_C1_OFS_L]};
   assign chan1_gain_word_top = reg_q[gbc_pkg::IDX_C1_GAN_H];

   // ---------------- checks ----------------
   // pin reads are only checkable once the synchroniser holds real samples
   logic [1:0] warm_q;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         warm_q <= 2'h0;
      end else if (warm_q != 2'h3) begin
         warm_q <= warm_q + 2'h1;
      end
   end

   logic wr_dir;
   logic wr_data_reg;
   logic wr_buf2;
   logic rd_data_reg;
   logic rd_buf1;

   assign wr_dir = wr_en && (addr == OFS[gbc_pkg::IDX_DIR]);
   assign wr_data_reg = wr_en && (addr == OFS[gbc_pkg::IDX_DATA]);
   assign wr_buf2 = wr_en && (addr == OFS[gbc_pkg::IDX_BUF2]);
   assign rd_data_reg = rd_en && (addr == OFS[gbc_pkg::IDX_DATA]);
   assign rd_buf1 = rd_en && (addr == OFS[gbc_pkg::IDX_BUF1]);

   // a read right at reset release cannot be issued, so track "not yet rewritten" instead
   logic buf1_clean_q;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         buf1_clean_q <= 1'b1;
      end else if (wr_en && (addr == OFS[gbc_pkg::IDX_BUF1])) begin
         buf1_clean_q <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking

   default disable iff (reset);

   property p_dir_reset;
      $fell(reset) |-> gpio_oe == 3'h0;
   endproperty
   a_dir_reset: assert property (p_dir_reset)
      else $error("pins not inputs after reset");

   property p_dir_write;
      wr_dir |=> gpio_oe == $past(wr_data[2:0]);
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction write did not reach output enables");

   property p_pin_drive;
      wr_data_reg |=> gpio_out == $past(wr_data[2:0]) ##1 ($stable(gpio_out) || $past(wr_en));
   endproperty
   a_pin_drive: assert property (p_pin_drive)
      else $error("pin output values wrong after data write");

   property p_pin_sample;
      rd_data_reg && warm_q == 2'h3 && $stable(gpio_in) && $past(gpio_in) == $past(gpio_in, 2)
         |=> rd_data[5:3] == $past(gpio_in, 2);
   endproperty
   a_pin_sample: assert property (p_pin_sample)
      else $error("read field does not show sampled pin levels");

   property p_buf_reset;
      $fell(reset) |-> pos_ref_buffer_on && neg_ref_buffer_on;
   endproperty
   a_buf_reset: assert property (p_buf_reset)
      else $error("reference buffers not enabled after reset");

   property p_pre_reset;
      $fell(reset) |-> pos_ref_precharge_on && neg_ref_precharge_on;
   endproperty
   a_pre_reset: assert property (p_pre_reset)
      else $error("precharge not enabled after reset");

   property p_od_write;
      wr_buf2 |=> {analog_reg1_overdrive, analog_reg2_overdrive, digital_reg_overdrive}
         == $past(wr_data[2:0]) && pos_ref_precharge_on == $past(wr_data[7]);
   endproperty
   a_od_write: assert property (p_od_write)
      else $error("buffer config 2 write not reflected");

   property p_od_reset;
      $fell(reset) |-> !analog_reg1_overdrive && !analog_reg2_overdrive
         && !digital_reg_overdrive;
   endproperty
   a_od_reset: assert property (p_od_reset)
      else $error("overdrive enabled after reset");

   property p_c0_offset;
      wr_en && addr == OFS[gbc_pkg::IDX_C0_OFS_H]
         |=> chan0_offset_word == {$past(wr_data), $past(chan0_offset_word[15:0])};
   endproperty
   a_c0_offset: assert property (p_c0_offset)
      else $error("offset high byte landed in wrong place");

   property p_c0_gain;
      wr_en && addr == OFS[gbc_pkg::IDX_C0_GAN_L]
         |=> chan0_gain_word == {$past(chan0_gain_word[23:8]), $past(wr_data)};
   endproperty
   a_c0_gain: assert property (p_c0_gain)
      else $error("gain low byte landed in wrong place");

   property p_c1_words;
      wr_en && addr == OFS[gbc_pkg::IDX_C1_GAN_H]
         |=> chan1_gain_word_top == $past(wr_data) && $stable(chan1_offset_word);
   endproperty
   a_c1_words: assert property (p_c1_words)
      else $error("channel 1 gain top byte write wrong");

   property p_buf1_read;
      rd_buf1 && buf1_clean_q |=> rd_data == `GBC_RST_BUF1;
   endproperty
   a_buf1_read: assert property (p_buf1_read)
      else $error("buffer config 1 reset readback wrong");

   property p_sample_write;
      wr_data_reg ##1 rd_data_reg && !wr_en
         |=> rd_data[2:0] == $past(wr_data[2:0], 2);
   endproperty
   a_sample_write: assert property (p_sample_write)
      else $error("output field lost when writing pin data register");

   property p_unmapped_read;
      rd_en && addr == ADDR_W'(8'h1B) |=> rd_data == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read returned data");

   property p_buf1_write;
      wr_en && addr == OFS[gbc_pkg::IDX_BUF1]
         |=> {pos_ref_buffer_on, neg_ref_buffer_on} == $past(wr_data[4:3]);
   endproperty
   a_buf1_write: assert property (p_buf1_write)
      else $error("buffer enables do not follow write");

   property p_neg_pre;
      wr_buf2 |=> neg_ref_precharge_on == $past(wr_data[6]);
   endproperty
   a_neg_pre: assert property (p_neg_pre)
      else $error("negative precharge enable does not follow write");

   property p_rd_idle;
      !rd_en |=> rd_data == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data shown without a read");

   property p_c0_offset_low;
      wr_en && addr == OFS[gbc_pkg::IDX_C0_OFS_L]
         |=> chan0_offset_word == {$past(chan0_offset_word[23:8]), $past(wr_data)};
   endproperty
   a_c0_offset_low: assert property (p_c0_offset_low)
      else $error("offset low byte landed in wrong place");

   property p_c0_gain_high;
      wr_en && addr == OFS[gbc_pkg::IDX_C0_GAN_H]
         |=> chan0_gain_word == {$past(wr_data), $past(chan0_gain_word[15:0])};
   endproperty
   a_c0_gain_high: assert property (p_c0_gain_high)
      else $error("gain high byte landed in wrong place");

   property p_c1_offset_low;
      wr_en && addr == OFS[gbc_pkg::IDX_C1_OFS_L]
         |=> chan1_offset_word == {$past(chan1_offset_word[23:8]), $past(wr_data)};
   endproperty
   a_c1_offset_low: assert property (p_c1_offset_low)
      else $error("channel 1 offset low byte landed in wrong place");

   property p_unmapped_write;
      wr_en && hit_wr == '0 |=> $stable(chan0_offset_word) && $stable(chan0_gain_word)
         && $stable(chan1_offset_word) && $stable(gpio_oe) && $stable(gpio_out);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write)
      else $error("unmapped write changed a register");

   property p_data_reserved;
      wr_data_reg ##1 rd_data_reg && !wr_en
         |=> rd_data[7:6] == $past(wr_data[7:6], 2);
   endproperty
   a_data_reserved: assert property (p_data_reserved)
      else $error("reserved bits of pin data register not stored");

   c_dir_then_drive: cover property (wr_dir ##1 wr_data_reg ##1 gpio_oe != 3'h0);
   c_pin_read: cover property (rd_data_reg ##1 rd_data[5:3] != 3'h0);
   c_cal_word: cover property (chan0_gain_word == 24'hFFFFFF);
   c_buf_off: cover property (!pos_ref_buffer_on && !neg_ref_buffer_on);
endmodule
`default_nettype wire

// file: bench/test_gpio_buffer_calib_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_gpio_buffer_calib_regs;
   logic clk_sys, reset, wr_en, rd_en;
   logic [7:0] addr;
   gbc_pkg::gbc_byte_t wr_data, rd_data, exp_rd, c1_top;
   logic [2:0] gpio_in, gpio_out, gpio_oe, pin_exp, pin_drv;
   logic pos_buf, neg_buf, pos_pre, neg_pre, od1, od2, odd;
   gbc_pkg::gbc_word_t c0_ofs, c0_gain, c1_ofs;
   logic [7:0] m [8'h17:8'h25];
   int n_fail, check_count, seed, r;

   gbc_regs_top dut_u (
      .clk_sys(clk_sys), .reset(reset), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .gpio_in(gpio_in),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pos_ref_buffer_on(pos_buf),
      .neg_ref_buffer_on(neg_buf), .pos_ref_precharge_on(pos_pre),
      .neg_ref_precharge_on(neg_pre), .analog_reg1_overdrive(od1),
      .analog_reg2_overdrive(od2), .digital_reg_overdrive(odd),
      .chan0_offset_word(c0_ofs), .chan0_gain_word(c0_gain),
      .chan1_offset_word(c1_ofs), .chan1_gain_word_top(c1_top)
   );

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic cmp_rd(input string what, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cmp_out(input string what, input logic [23:0] e, input logic [23:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   function automatic logic mapped(input logic [7:0] a);
      return (a >= 8'h17) && (a <= 8'h25) && (a != 8'h1B);
   endfunction

   function automatic logic [7:0] model_read(input logic [7:0] a);
      if (!mapped(a)) return 8'h00;
      if (a == 8'h18) return m[a] | {2'b00, pin_exp, 3'b000};
      return m[a];
   endfunction

   task automatic model_reset();
      for (int k = 8'h17; k <= 8'h25; k++) begin
         m[k] = 8'h00;
      end
      m[8'h19] = 8'h38;
      m[8'h1A] = 8'hC0;
      pin_exp = 3'b000;
      exp_rd = 8'h00;
   endtask

   // one bus cycle; outputs are judged 10 ns after the edge, once settled
   task automatic bus(input int op, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_en <= (op == 1);
      rd_en <= (op == 2);
      gpio_in <= pin_drv;
      #10;
      cmp_rd("rd_data", exp_rd, rd_data);
      cmp_out("pins and controls", {11'h0, m[8'h17][2:0], m[8'h18][2:0], m[8'h19][4:3],
         m[8'h1A][7:6], m[8'h1A][2:0]}, {11'h0, gpio_oe, gpio_out, pos_buf, neg_buf,
         pos_pre, neg_pre, od1, od2, odd});
      cmp_out("chan0 offset", {m[8'h1C], m[8'h1D], m[8'h1E]}, c0_ofs);
      cmp_out("chan0 gain", {m[8'h1F], m[8'h20], m[8'h21]}, c0_gain);
      cmp_out("chan1 offset", {m[8'h22], m[8'h23], m[8'h24]}, c1_ofs);
      cmp_out("chan1 gain top", {16'h0, m[8'h25]}, {16'h0, c1_top});
      exp_rd = (op == 2) ? model_read(a) : 8'h00;
      if (op == 1 && mapped(a)) m[a] = (a == 8'h18) ? (d & 8'hC7) : d;
   endtask

   task automatic do_reset();
      @(posedge clk_sys);
      reset <= 1'b1;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      model_reset();
   endtask

   // the pin synchroniser needs two edges; three idle cycles leave margin
   task automatic set_pins(input logic [2:0] v);
      pin_drv = v;
      repeat (3) bus(0, 8'h00, 8'h00);
      pin_exp = v;
   endtask

   task automatic read_all();
      for (int a = 8'h16; a <= 8'h26; a++) begin
         bus(2, 8'(a), 8'h00);
      end
      bus(0, 8'h00, 8'h00);
   endtask

   task end_sim();
      $display("comparisons %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #(50 * 3000);
      n_fail++;
      end_sim();
   end

   initial begin
      reset = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wr_data = 8'h00;
      gpio_in = 3'b000;
      pin_drv = 3'b000;
      n_fail = 0;
      check_count = 0;
      seed = 29513;
      model_reset();
      do_reset();
      read_all();
      // every mapped byte written and read back with no gap
      for (int a = 8'h17; a <= 8'h25; a++) begin
         bus(1, 8'(a), 8'(a) ^ 8'hA5);
         bus(2, 8'(a), 8'h00);
      end
      bus(1, 8'h18, 8'hFF);
      bus(2, 8'h18, 8'h00);
      bus(1, 8'h1B, 8'hFF);
      bus(1, 8'h97, 8'hFF);
      bus(2, 8'h1B, 8'h00);
      bus(2, 8'h97, 8'h00);
      for (int v = 0; v < 8; v++) begin
         bus(1, 8'h17, {5'h00, 3'(v)});
         set_pins(~3'(v));
         bus(2, 8'h18, 8'h00);
      end
      // random traffic over mapped and neighbouring unmapped offsets
      for (int n = 0; n < 240; n++) begin
         if (n % 60 == 0) set_pins(3'($random(seed)));
         r = $random(seed);
         bus((r[1:0] == 2'b11) ? 2 : int'(r[1:0]), 8'h15 + ({3'b000, r[12:8]} % 8'd19),
            r[23:16]);
      end
      bus(0, 8'h00, 8'h00);
      pin_drv = 3'b101;
      do_reset();
      pin_exp = 3'b000;
      repeat (2) bus(0, 8'h00, 8'h00);
      pin_exp = 3'b101;
      read_all();
      end_sim();
   end
endmodule
`default_nettype wire
